// ===== hw/rfp_const_gen.sv
`timescale 1ns/1ps
`default_nettype none
// constant generator: decodes the source register and mode
module rfp_const_gen (
  // request
  input wire logic [3:0] src_idx,
  input wire logic [1:0] source_addr_mode,
  // answer
  output logic is_const,
  output logic [15:0] const_value
);
  // reg two yields +4/+8 in indirect modes, reg three always a constant
  always_comb begin
    is_const = 1'b0;
    const_value = rfp_pkg::CG_ZERO;
    if (src_idx == rfp_pkg::IDX_CONST) begin
      is_const = 1'b1;
      case (source_addr_mode)
        rfp_pkg::AS_REG: const_value = rfp_pkg::CG_ZERO;
        rfp_pkg::AS_INDEX: const_value = rfp_pkg::CG_ONE;
        rfp_pkg::AS_IND: const_value = rfp_pkg::CG_TWO;
        default: const_value = rfp_pkg::CG_ALL_ONES;
      endcase
    end else if (src_idx == rfp_pkg::IDX_FLAGS_CONST) begin
      case (source_addr_mode)
        rfp_pkg::AS_IND: begin
          is_const = 1'b1;
          const_value = rfp_pkg::CG_FOUR;
        end
        rfp_pkg::AS_AUTOINC: begin
          is_const = 1'b1;
          const_value = rfp_pkg::CG_EIGHT;
        end
        rfp_pkg::AS_INDEX: begin
          // absolute mode: base of zero added to the next word
          is_const = 1'b1;
          const_value = rfp_pkg::CG_ZERO;
        end
        default: is_const = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== hw/rfp_reg_store.sv
`timescale 1ns/1ps
`default_nettype none
// general working registers, one write port, three registered reads
module rfp_reg_store #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 12
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // write port with byte enables
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [1:0] wr_be,
  input wire logic [WIDTH-1:0] wr_data,
  // read ports
  input wire logic [3:0] rd_addr_a,
  input wire logic [3:0] rd_addr_b,
  input wire logic [3:0] rd_addr_c,
  output logic [WIDTH-1:0] rd_data_a,
  output logic [WIDTH-1:0] rd_data_b,
  output logic [WIDTH-1:0] rd_data_c
);
  logic [WIDTH-1:0] mem [DEPTH];

  // elaboration check: the byte lanes below are wired for a 16-bit word
  if (WIDTH != 16 || DEPTH < 1 || DEPTH > 16) begin : g_bad_size
    $error("rfp_reg_store: unsupported width or depth");
  end

  // each entry updates its own byte lanes
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        mem[i] <= '0;
      end else if (wr_en && wr_addr == 4'(i)) begin
        if (wr_be[0]) mem[i][7:0] <= wr_data[7:0];
        if (wr_be[1]) mem[i][15:8] <= wr_data[15:8];
      end
    end
  end

  // registered reads; out of range reads return zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_a <= '0;
      rd_data_b <= '0;
      rd_data_c <= '0;
    end else begin
      rd_data_a <= (32'(rd_addr_a) < DEPTH) ? mem[rd_addr_a] : '0;
      rd_data_b <= (32'(rd_addr_b) < DEPTH) ? mem[rd_addr_b] : '0;
      rd_data_c <= (32'(rd_addr_c) < DEPTH) ? mem[rd_addr_c] : '0;
    end
  end
endmodule
`default_nettype wire

// ===== hw/rfp_register_file.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - sixteen 16-bit registers, four dedicated, twelve general working.
// - instruction pointer always holds the next instruction address.
// - pointer advances by two, four or six bytes per instruction.
// - fetch address on word boundaries, pointer kept even.
// - any write to the instruction pointer acts as a branch.
// - calls and accepted interrupts push return addresses via stack pointer.
// - stack pointer decrements before a store, increments after a load.
// - stack pointer readable and writable like any register.
// - software loads the stack pointer into RAM; it stays even.
// - pushing the stack pointer stores old value, then it decrements.
// - popping into the stack pointer loads the value, no increment.
// - a 16-bit address bus reaches the whole memory range.
// - word and byte operand access over the 16-bit data path.
// - memory-to-memory moves pass a latch, not a working register.
// - six common immediates come from constant generation hardware.
// - reg three gives 0,1,2,all ones; reg two gives 4 or 8.
// - general registers serve as data, pointer or index, byte or word.
module rfp_register_file #(
  parameter int unsigned GP_COUNT = 12
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // instruction pointer control
  input wire logic ip_advance,
  input wire logic [1:0] ip_len_words,
  // source operand read
  input wire logic [3:0] src_idx,
  input wire logic [1:0] source_addr_mode,
  input wire logic src_byte,
  output logic [15:0] src_data,
  output logic src_is_const,
  // second operand read
  input wire logic [3:0] dst_idx,
  input wire logic dst_byte,
  output logic [15:0] dst_data,
  // register write
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic wr_byte,
  input wire logic [15:0] wr_data,
  // stack operations
  input wire logic [1:0] stack_op,
  input wire logic [3:0] push_idx,
  input wire logic [15:0] pop_data,
  input wire logic [3:0] pop_idx,
  input wire logic call_or_irq,
  // memory-to-memory transfer latch
  input wire logic move_load,
  input wire logic [15:0] move_data,
  output logic [15:0] move_value,
  // memory address and store data
  output logic [15:0] fetch_addr,
  output logic [15:0] stack_addr,
  output logic [15:0] stack_store_data,
  output logic stack_store,
  // dedicated register views
  output logic [15:0] instruction_pointer,
  output logic [15:0] stack_top_pointer,
  output logic [15:0] reg_two_flags_const
);
  localparam int unsigned FIRST_GP = 4;

  // elaboration checks: the index decode below assumes this exact map
  if (GP_COUNT != 12) begin : g_bad_count
    $error("rfp_register_file: twelve working registers required");
  end
  // four dedicated registers plus the working set must fill the index
  if (FIRST_GP + GP_COUNT != rfp_pkg::REG_COUNT) begin : g_bad_map
    $error("rfp_register_file: register map does not fill the index");
  end

  // reset release through two flip-flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // stack request; the unused code three acts as no operation
  rfp_pkg::rfp_stack_op_t op;
  assign op = rfp_pkg::rfp_stack_op_t'(stack_op);

  // datapath nets
  logic [15:0] reg_three_const;
  logic [15:0] stack_value_before;
  logic [15:0] stack_value_after;
  logic [15:0] next_ip;
  logic [15:0] next_sp;
  logic [15:0] push_value;
  logic [15:0] const_value;
  logic is_const;
  logic [15:0] gp_a;
  logic [15:0] gp_b;
  logic [15:0] gp_c;
  logic [15:0] ip_step;
  logic [1:0] wr_be;
  logic gp_wr_en;
  logic [3:0] gp_wr_addr;
  logic [15:0] gp_wr_data;

  // reg three holds nothing; its register-mode read is the zero constant
  assign reg_three_const = rfp_pkg::CG_ZERO; // reads as zero in register mode
  assign stack_value_before = stack_top_pointer;

  // instruction length in bytes, a word count of 1..3 doubled
  always_comb begin
    case (ip_len_words)
      rfp_pkg::LEN_TWO_WORDS: ip_step = rfp_pkg::STEP_TWO_WORDS;
      rfp_pkg::LEN_THREE_WORDS: ip_step = rfp_pkg::STEP_THREE_WORDS;
      default: ip_step = rfp_pkg::WORD_STEP;
    endcase
  end

  // a register write to the pointer wins over advancing: it is a branch
  always_comb begin
    next_ip = instruction_pointer;
    if (wr_en && wr_idx == rfp_pkg::IDX_IP) begin
      next_ip = wr_data & rfp_pkg::EVEN_MASK;
    end else if (op == rfp_pkg::STK_POP && pop_idx == rfp_pkg::IDX_IP) begin
      next_ip = pop_data & rfp_pkg::EVEN_MASK;
    end else if (ip_advance) begin
      next_ip = instruction_pointer + ip_step;
    end
  end

  // pointer register; the mask keeps it even whatever the source
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      instruction_pointer <= rfp_pkg::IP_RESET;
    end else begin
      instruction_pointer <= next_ip & rfp_pkg::EVEN_MASK;
    end
  end

  // value stored by a push; calls and interrupts save the return address
  // working registers come from read port c, so push_idx leads by a cycle
  always_comb begin
    if (call_or_irq) begin
      push_value = instruction_pointer;
    end else begin
      case (push_idx)
        rfp_pkg::IDX_IP: push_value = instruction_pointer;
        rfp_pkg::IDX_STACK: push_value = stack_value_before;
        rfp_pkg::IDX_FLAGS_CONST: push_value = reg_two_flags_const;
        rfp_pkg::IDX_CONST: push_value = reg_three_const;
        default: push_value = gp_c;
      endcase
    end
  end

  // stack pointer: predecrement on store, postincrement on load
  // a plain write to the stack pointer loses to a push or pop that cycle
  always_comb begin
    next_sp = stack_top_pointer;
    stack_addr = stack_top_pointer;
    case (op)
      rfp_pkg::STK_PUSH: begin
        next_sp = stack_top_pointer - rfp_pkg::WORD_STEP;
        stack_addr = next_sp;
      end
      rfp_pkg::STK_POP: begin
        if (pop_idx == rfp_pkg::IDX_STACK) begin
          next_sp = pop_data;
        end else begin
          next_sp = stack_top_pointer + rfp_pkg::WORD_STEP;
        end
      end
      default: begin
        if (wr_en && wr_idx == rfp_pkg::IDX_STACK) begin
          next_sp = wr_data;
        end
      end
    endcase
  end
  assign stack_value_after = next_sp & rfp_pkg::EVEN_MASK;

  // stack pointer register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stack_top_pointer <= rfp_pkg::STACK_RESET;
    end else begin
      stack_top_pointer <= stack_value_after;
    end
  end

  // store strobe and data for the memory bus, both in the request cycle
  assign stack_store = (op == rfp_pkg::STK_PUSH);
  assign stack_store_data = push_value;

  // fetches come straight from the pointer, which is always even
  assign fetch_addr = instruction_pointer;

  // flags register: any register write loads the full word, whatever the mode or byte flag
  // a pop of the flags wins over a write, as for every register but the instruction pointer, where a write wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_two_flags_const <= '0;
    end else if (op == rfp_pkg::STK_POP &&
                 pop_idx == rfp_pkg::IDX_FLAGS_CONST) begin
      reg_two_flags_const <= pop_data;
    end else if (wr_en && wr_idx == rfp_pkg::IDX_FLAGS_CONST) begin
      reg_two_flags_const <= wr_data;
    end
  end

  // general registers: byte writes touch low lane and clear the high lane
  // a pop into a working register wins over a write in the same cycle
  always_comb begin
    gp_wr_en = 1'b0;
    gp_wr_addr = 4'h0;
    gp_wr_data = wr_data;
    wr_be = 2'h3;
    if (op == rfp_pkg::STK_POP && pop_idx >= 4'(FIRST_GP)) begin
      gp_wr_en = 1'b1;
      gp_wr_addr = pop_idx - 4'(FIRST_GP);
      gp_wr_data = pop_data;
    end else if (wr_en && wr_idx >= 4'(FIRST_GP)) begin
      gp_wr_en = 1'b1;
      gp_wr_addr = wr_idx - 4'(FIRST_GP);
      gp_wr_data = wr_byte ? {8'h00, wr_data[7:0]} : wr_data;
    end
  end

  rfp_reg_store #(
    .WIDTH(rfp_pkg::DATA_W),
    .DEPTH(GP_COUNT)
  ) u_store (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(gp_wr_en),
    .wr_addr(gp_wr_addr),
    .wr_be(wr_be),
    .wr_data(gp_wr_data),
    .rd_addr_a(src_idx - 4'(FIRST_GP)),
    .rd_addr_b(dst_idx - 4'(FIRST_GP)),
    .rd_addr_c(push_idx - 4'(FIRST_GP)),
    .rd_data_a(gp_a),
    .rd_data_b(gp_b),
    .rd_data_c(gp_c)
  );

  rfp_const_gen u_cg (
    .src_idx(src_idx),
    .source_addr_mode(source_addr_mode),
    .is_const(is_const),
    .const_value(const_value)
  );

  // registered read stage; selectors aligned with the store's latency
  logic [3:0] src_idx_q;
  logic [3:0] dst_idx_q;
  logic src_byte_q;
  logic dst_byte_q;
  logic is_const_q;
  logic [15:0] const_q;
  logic [15:0] src_ded_q;
  logic [15:0] dst_ded_q;

  // request qualifiers delayed to line up with the store's read latency
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      src_idx_q <= 4'h0;
      dst_idx_q <= 4'h0;
      src_byte_q <= 1'b0;
      dst_byte_q <= 1'b0;
      is_const_q <= 1'b0;
      const_q <= '0;
    end else begin
      src_idx_q <= src_idx;
      dst_idx_q <= dst_idx;
      src_byte_q <= src_byte;
      dst_byte_q <= dst_byte;
      is_const_q <= is_const;
      const_q <= const_value;
    end
  end

  // dedicated source captured with the same one-cycle latency
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      src_ded_q <= '0;
    end else begin
      case (src_idx)
        rfp_pkg::IDX_IP: src_ded_q <= instruction_pointer;
        rfp_pkg::IDX_STACK: src_ded_q <= stack_top_pointer;
        rfp_pkg::IDX_FLAGS_CONST: src_ded_q <= reg_two_flags_const;
        default: src_ded_q <= reg_three_const;
      endcase
    end
  end

  // dedicated second operand, same latency as the source
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dst_ded_q <= '0;
    end else begin
      case (dst_idx)
        rfp_pkg::IDX_IP: dst_ded_q <= instruction_pointer;
        rfp_pkg::IDX_STACK: dst_ded_q <= stack_top_pointer;
        rfp_pkg::IDX_FLAGS_CONST: dst_ded_q <= reg_two_flags_const;
        default: dst_ded_q <= reg_three_const;
      endcase
    end
  end

  // output select; byte reads return the low byte zero extended
  logic [15:0] src_raw;
  logic [15:0] dst_raw;
  // source: a generated constant replaces the register contents
  always_comb begin
    src_raw = (src_idx_q >= 4'(FIRST_GP)) ? gp_a : src_ded_q;
    if (is_const_q) begin
      src_raw = const_q;
    end
    src_data = src_byte_q ? {8'h00, src_raw[7:0]} : src_raw;
    src_is_const = is_const_q;
  end

  // second operand never passes through the constant generator
  always_comb begin
    dst_raw = (dst_idx_q >= 4'(FIRST_GP)) ? gp_b : dst_ded_q;
    dst_data = dst_byte_q ? {8'h00, dst_raw[7:0]} : dst_raw;
  end

  // memory-to-memory latch keeps data out of the working registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      move_value <= '0;
    end else if (move_load) begin
      move_value <= move_data;
    end
  end
endmodule
`default_nettype wire

// ===== include/rfp_pkg.sv
package rfp_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned REG_COUNT = 16;
  localparam int unsigned IDX_W = 4;
  localparam logic [3:0] IDX_IP = 4'h0;
  localparam logic [3:0] IDX_STACK = 4'h1;
  localparam logic [3:0] IDX_FLAGS_CONST = 4'h2;
  localparam logic [3:0] IDX_CONST = 4'h3;
  localparam logic [15:0] IP_RESET = 16'h0000;
  localparam logic [15:0] STACK_RESET = 16'h0000;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] STEP_TWO_WORDS = 16'h0004;
  localparam logic [15:0] STEP_THREE_WORDS = 16'h0006;
  localparam logic [15:0] EVEN_MASK = 16'hfffe;
  // source addressing modes
  localparam logic [1:0] AS_REG = 2'h0;
  localparam logic [1:0] AS_INDEX = 2'h1;
  localparam logic [1:0] AS_IND = 2'h2;
  localparam logic [1:0] AS_AUTOINC = 2'h3;
  // generated constants
  localparam logic [15:0] CG_ZERO = 16'h0000;
  localparam logic [15:0] CG_ONE = 16'h0001;
  localparam logic [15:0] CG_TWO = 16'h0002;
  localparam logic [15:0] CG_FOUR = 16'h0004;
  localparam logic [15:0] CG_EIGHT = 16'h0008;
  localparam logic [15:0] CG_ALL_ONES = 16'hffff;
  // instruction lengths in words
  localparam logic [1:0] LEN_ONE_WORD = 2'h1;
  localparam logic [1:0] LEN_TWO_WORDS = 2'h2;
  localparam logic [1:0] LEN_THREE_WORDS = 2'h3;
  // stack operations
  typedef enum logic [1:0] {
    STK_NONE,
    STK_PUSH,
    STK_POP
  } rfp_stack_op_t;
endpackage

// ===== sim/rfp_register_file_bench.sv
`timescale 1ns/1ps
`default_nettype none
// directed run over pointers, stack, constants and byte access
module rfp_register_file_bench;
  logic mclk, resetn, ip_advance, src_byte, dst_byte, wr_en, wr_byte;
  logic call_or_irq, move_load, stack_store, src_is_const;
  logic [1:0] ip_len_words, source_addr_mode, stack_op;
  logic [3:0] src_idx, dst_idx, wr_idx, push_idx, pop_idx;
  logic [15:0] wr_data, pop_data, move_data, src_data, dst_data, move_value;
  logic [15:0] fetch_addr, stack_addr, stack_store_data, reg_two_flags_const;
  logic [15:0] instruction_pointer, stack_top_pointer, ip, sp;
  int mismatches, total_checks;
  localparam logic [15:0] CONST_EXP [6] = '{16'h0000, 16'h0001, 16'h0002,
    16'hffff, 16'h0004, 16'h0008};
  rfp_register_file dut (.mclk, .resetn, .ip_advance, .ip_len_words,
    .src_idx, .source_addr_mode, .src_byte, .src_data, .src_is_const,
    .dst_idx, .dst_byte, .dst_data, .wr_en, .wr_idx, .wr_byte, .wr_data,
    .stack_op, .push_idx, .pop_data, .pop_idx, .call_or_irq, .move_load,
    .move_data, .move_value, .fetch_addr, .stack_addr, .stack_store_data,
    .stack_store, .instruction_pointer, .stack_top_pointer,
    .reg_two_flags_const);
  rfp_stack_mem mem (.mclk, .stack_addr, .stack_store, .stack_store_data,
    .pop_rd(stack_op == rfp_pkg::STK_POP), .pop_data);
  task automatic chk(input string what, input logic [15:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done;
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one clock; requests are taken at the rising edge in between
  task automatic step_clk;
    @(negedge mclk);
    ip_advance = 1'b0;
    wr_en = 1'b0;
    stack_op = 2'h0;
    move_load = 1'b0;
    call_or_irq = 1'b0;
  endtask
  task automatic wr(input logic [3:0] idx, input logic [15:0] d,
    input logic b);
    wr_en = 1'b1;
    wr_idx = idx;
    wr_data = d;
    wr_byte = b;
    step_clk;
  endtask
  task automatic rd_dst(input logic [3:0] idx, input logic b,
    input logic [15:0] exp);
    dst_idx = idx;
    dst_byte = b;
    @(negedge mclk);
    chk("dst_data", exp, dst_data);
  endtask
  // push_idx leads by a cycle so the working register is read in time;
  // the bus is checked in the request cycle, then the lowered pointer
  task automatic push(input logic [3:0] idx, input logic call,
    input logic [15:0] exp);
    push_idx = idx;
    @(negedge mclk);
    stack_op = rfp_pkg::STK_PUSH;
    call_or_irq = call;
    #1;
    chk("stack_addr", sp - 16'h0002, stack_addr);
    chk("stack_store", 16'h0001, {15'h0000, stack_store});
    chk("stack_store_data", exp, stack_store_data);
    step_clk;
    sp = sp - 16'h0002;
    chk("stack_top_pointer", sp, stack_top_pointer);
  endtask
  task automatic pop(input logic [3:0] idx, input logic [15:0] exp_sp);
    stack_op = rfp_pkg::STK_POP;
    pop_idx = idx;
    step_clk;
    sp = exp_sp;
    chk("stack_top_pointer", sp, stack_top_pointer);
  endtask
  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  // the directed run takes about fifty cycles
  initial begin
    #100us;
    mismatches++;
    test_done;
  end
  initial begin
    {resetn, ip_advance, src_byte, dst_byte, wr_en, wr_byte} = '0;
    {call_or_irq, move_load, ip_len_words, source_addr_mode} = '0;
    {stack_op, src_idx, dst_idx, wr_idx, push_idx, pop_idx} = '0;
    {wr_data, move_data} = '0;
    repeat (16) @(negedge mclk);
    resetn = 1'b1;
    repeat (4) @(negedge mclk);
    ip = 16'h0000;
    chk("instruction_pointer", ip, instruction_pointer);
    for (int n = 0; n < 4; n++) begin
      ip_advance = 1;
      ip_len_words = n[1:0];
      step_clk;
      ip = ip + ((n == 0) ? 16'h0002 : 16'(2 * n));
      chk("instruction_pointer", ip, instruction_pointer);
      chk("fetch_addr", ip, fetch_addr);
    end
    ip_advance = 1;
    wr(rfp_pkg::IDX_IP, 16'h1235, 0);
    chk("instruction_pointer", 16'h1234, instruction_pointer);
    wr(rfp_pkg::IDX_STACK, 16'h0401, 0);
    sp = 16'h0400;
    chk("stack_top_pointer", sp, stack_top_pointer);
    src_idx = rfp_pkg::IDX_STACK;
    @(negedge mclk);
    chk("src_data", sp, src_data);
    for (int i = 0; i < 6; i++) begin
      src_idx = (i < 4) ? rfp_pkg::IDX_CONST : rfp_pkg::IDX_FLAGS_CONST;
      source_addr_mode = (i < 4) ? i[1:0] : 2'(i - 2);
      @(negedge mclk);
      chk("src_data", CONST_EXP[i], src_data);
      chk("src_is_const", 16'h0001, {15'h0000, src_is_const});
    end
    // flags register: plain register mode, then the absolute-mode zero
    wr(rfp_pkg::IDX_FLAGS_CONST, 16'h0107, 0);
    chk("reg_two_flags_const", 16'h0107, reg_two_flags_const);
    source_addr_mode = rfp_pkg::AS_REG;
    @(negedge mclk);
    chk("src_data", 16'h0107, src_data);
    chk("src_is_const", 16'h0000, {15'h0000, src_is_const});
    source_addr_mode = rfp_pkg::AS_INDEX;
    @(negedge mclk);
    chk("src_data", 16'h0000, src_data);
    wr(4'h5, 16'h0a5b, 0);
    rd_dst(4'h5, 1, 16'h005b);
    wr(4'h7, 16'h12ab, 1);
    rd_dst(4'h7, 0, 16'h00ab);
    push(4'h5, 0, 16'h0a5b);
    push(rfp_pkg::IDX_STACK, 0, 16'h03fe);
    push(4'h5, 1, 16'h1234);
    pop(4'h6, 16'h03fc);
    rd_dst(4'h6, 0, 16'h1234);
    pop(4'h6, 16'h03fe);
    rd_dst(4'h6, 0, 16'h03fe);
    pop(rfp_pkg::IDX_STACK, 16'h0a5a);
    move_load = 1;
    move_data = 16'hc3e1;
    step_clk;
    chk("move_value", 16'hc3e1, move_value);
    test_done;
  end
endmodule
`default_nettype wire

// ===== sim/rfp_register_file_chk.sv
`timescale 1ns/1ps
`default_nettype none
// pointer and stack relations watched at the top ports
module rfp_register_file_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // requests
  input wire logic ip_advance,
  input wire logic [1:0] ip_len_words,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] stack_op,
  input wire logic [3:0] push_idx,
  input wire logic [15:0] pop_data,
  input wire logic [3:0] pop_idx,
  input wire logic call_or_irq,
  input wire logic move_load,
  input wire logic [15:0] move_data,
  // answers
  input wire logic [15:0] move_value,
  input wire logic [15:0] fetch_addr,
  input wire logic [15:0] stack_addr,
  input wire logic [15:0] stack_store_data,
  input wire logic stack_store,
  input wire logic [15:0] instruction_pointer,
  input wire logic [15:0] stack_top_pointer
);
  logic push;
  logic pop;
  logic ip_wr;
  logic ip_pop;
  logic [15:0] step;
  // decoded requests; a length code of zero counts as one word
  assign push = stack_op == rfp_pkg::STK_PUSH;
  assign pop = stack_op == rfp_pkg::STK_POP;
  assign ip_wr = wr_en && wr_idx == rfp_pkg::IDX_IP;
  assign ip_pop = pop && pop_idx == rfp_pkg::IDX_IP;
  assign step = (ip_len_words == 2'h0) ? 16'h0002
              : {13'h0000, ip_len_words, 1'b0};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  chk_ip_even: assert property (!instruction_pointer[0])
    else $error("instruction pointer odd");
  chk_sp_even: assert property (!stack_top_pointer[0])
    else $error("stack pointer odd");
  chk_fetch_follows_ip: assert property (
    fetch_addr == instruction_pointer)
    else $error("fetch address not the pointer");
  chk_ip_advance: assert property (ip_advance && !ip_wr && !ip_pop |=>
    instruction_pointer == $past(instruction_pointer) + $past(step))
    else $error("pointer advanced by wrong length");
  chk_ip_branch: assert property (ip_wr && !ip_pop |=>
    instruction_pointer == ($past(wr_data) & 16'hfffe))
    else $error("pointer write not taken");
  chk_push_predec: assert property (push |->
    stack_store && stack_addr == stack_top_pointer - 16'h0002)
    else $error("push address not predecremented");
  chk_push_moves_sp: assert property (push |=>
    stack_top_pointer == $past(stack_top_pointer) - 16'h0002)
    else $error("push did not lower stack pointer");
  chk_pop_postinc: assert property (
    pop && pop_idx != rfp_pkg::IDX_STACK |=>
    stack_top_pointer == $past(stack_top_pointer) + 16'h0002)
    else $error("pop did not raise stack pointer");
  chk_pop_self: assert property (
    pop && pop_idx == rfp_pkg::IDX_STACK |=>
    stack_top_pointer == ($past(pop_data) & 16'hfffe))
    else $error("pop into stack pointer wrong");
  chk_push_self: assert property (
    push && push_idx == rfp_pkg::IDX_STACK && !call_or_irq |->
    stack_store_data == stack_top_pointer)
    else $error("pushed stack pointer value wrong");
  chk_call_return: assert property (push && call_or_irq |->
    stack_store_data == instruction_pointer)
    else $error("return address not stored");
  chk_move_latch: assert property (
    move_load |=> move_value == $past(move_data))
    else $error("move latch not loaded");
  cov_push: cover property (push ##2 push);
  cov_pop_self: cover property (pop && pop_idx == rfp_pkg::IDX_STACK);
  cov_branch: cover property (ip_wr && ip_advance);
endmodule
bind rfp_register_file rfp_register_file_chk chk (.mclk, .resetn,
  .ip_advance, .ip_len_words, .wr_en, .wr_idx, .wr_data, .stack_op,
  .push_idx, .pop_data, .pop_idx, .call_or_irq, .move_load, .move_data,
  .move_value, .fetch_addr, .stack_addr, .stack_store_data, .stack_store,
  .instruction_pointer, .stack_top_pointer);
`default_nettype wire

// ===== sim/rfp_stack_mem.sv
`timescale 1ns/1ps
`default_nettype none
// stack ram on the core bus; answers a pop in the same cycle
module rfp_stack_mem (
  // clock
  input wire logic mclk,
  // store side
  input wire logic [15:0] stack_addr,
  input wire logic stack_store,
  input wire logic [15:0] stack_store_data,
  // load side
  input wire logic pop_rd,
  output logic [15:0] pop_data
);
  logic [15:0] mem [256];
  // filled with a pattern so no load ever returns an unknown
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'ha5a5 ^ 16'(i);
    end
  end
  // word ram, bit 0 of the address is ignored
  always @(posedge mclk) begin
    if (stack_store) begin
      mem[stack_addr[8:1]] <= stack_store_data;
    end
  end
  // outside a pop the bus shows the inverse, never a stale word
  assign pop_data = pop_rd ? mem[stack_addr[8:1]] : ~mem[stack_addr[8:1]];
endmodule
`default_nettype wire
